// [design/dfl_map.vh]
// Purpose: Register indexes, reset values, field positions for the fan threshold loop
// Assumes: Byte address of a register is four times its index
// Notes: Temperature codes are degrees Celsius plus 64
`ifndef DFL_MAP_VH
`define DFL_MAP_VH

// Register indexes
`define DFL_IDX_CYCLE 8'h0C
`define DFL_IDX_OP1 8'h5A
`define DFL_IDX_OP2 8'h5B
`define DFL_IDX_HYST 8'h64
`define DFL_IDX_TMIN1 8'h70
`define DFL_IDX_TMIN2 8'h71
`define DFL_IDX_LOW1 8'h72
`define DFL_IDX_LOW2 8'h73
`define DFL_IDX_HIGH1 8'h74
`define DFL_IDX_HIGH2 8'h75
`define DFL_IDX_CRIT1 8'h76
`define DFL_IDX_CRIT2 8'h77
`define DFL_IDX_RANGE 8'h78
`define DFL_IDX_CTRL 8'h79
`define DFL_IDX_STATUS 8'h7A
`define DFL_IDX_MASK 8'h7B

// Reset values
`define DFL_RST_OP 8'hA4
`define DFL_RST_HYST 8'h40
`define DFL_RST_CYCLE 8'h00
`define DFL_RST_TMIN 8'h8C
`define DFL_RST_LOW 8'h82
`define DFL_RST_HIGH 8'h9A
`define DFL_RST_CRIT 8'hA4
`define DFL_RST_RANGE 8'h22
`define DFL_RST_CTRL 8'h00
`define DFL_RST_MASK 8'h00

// Fields
`define DFL_HYST_MSB 7
`define DFL_HYST_LSB 4
`define DFL_CYC_R1_MSB 2
`define DFL_CYC_R1_LSB 0
`define DFL_CYC_R2_MSB 5
`define DFL_CYC_R2_LSB 3
`define DFL_RANGE_R1_MSB 2
`define DFL_RANGE_R1_LSB 0
`define DFL_RANGE_R2_MSB 6
`define DFL_RANGE_R2_LSB 4
`define DFL_STAT_W 4

// Loop constants
`define DFL_SHORT_LOG2 3
`define DFL_RISE_QUIET 10'h001
`define DFL_DUTY_FULL 8'hFF
`define DFL_DUTY_OFF 8'h00

`endif

// [design/dfl_sticky.v]
// Purpose: Sticky event bits, cleared by a read of the bits that were read
// Assumes: Set and clear come from logic on pclk
// Notes: A set in the clearing cycle wins
`timescale 1ns/1ps
module dfl_sticky #(
  parameter W = 4
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Events and clear
  input wire [W-1:0] set,
  input wire [W-1:0] clr,
  // State
  output reg [W-1:0] q
);

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      q <= {W{1'b0}};
    else
      q <= (q & ~clr) | set;
  end

endmodule

// [design/dfl_cyc.v]
// Purpose: Short and long cycle pulse generator for one channel
// Assumes: mon_tick is a one-cycle pulse per monitoring cycle
// Notes: Short cycle every 8 << code ticks, long cycle every second short
`timescale 1ns/1ps
`include "dfl_map.vh"
module dfl_cyc #(
  parameter CNT_W = 11
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Timebase
  input wire mon_tick,
  input wire [2:0] cyc_sel,
  // Pulses
  output reg short_q,
  output reg long_q
);

  reg [CNT_W-1:0] cnt_q;
  reg half_q;
  wire [CNT_W-1:0] last_w;
  wire hit_w;

  assign last_w = ({{(CNT_W-1){1'b0}}, 1'b1} << (cyc_sel + `DFL_SHORT_LOG2)) - 1'b1;
  assign hit_w = mon_tick && (cnt_q >= last_w);

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_q <= {CNT_W{1'b0}};
      half_q <= 1'b0;
      short_q <= 1'b0;
      long_q <= 1'b0;
    end
    else
    begin
      short_q <= hit_w;
      long_q <= hit_w && half_q;
      if (hit_w)
      begin
        cnt_q <= {CNT_W{1'b0}};
        half_q <= ~half_q;
      end
      else if (mon_tick)
        cnt_q <= cnt_q + 1'b1;
    end
  end

endmodule

// [design/dfl_top.v]
// Purpose: Dynamic fan-on temperature loop for two remote channels with APB registers
// Assumes: Temperatures are 10-bit codes, degree code in [9:2], quarter degrees in [1:0]
// Notes: Zero wait state APB, unmapped index answers pslverr
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
`include "dfl_map.vh"
// Function
// - Temperature under low limit sets a sticky status flag and may raise the interrupt.
// - Temperature over high limit sets a sticky status flag and may raise the interrupt.
// - Fan-on temperature is where the channel's fan duty leaves zero.
// - Dynamic mode keeps each zone near its operating point by moving fan-on temperature.
// - Above the critical limit the fan duty goes full.
// - A range field sets the duty slope against temperature.
// - Zone below operating point with fan-on too low raises fan-on temperature.
// - Operating point exceeded with fan-on too high lowers fan-on temperature.
// - Two eight-bit operating point registers, one degree per step.
// - Operating points at 0x5A and 0x5B, reset to 0xA4.
// - Hysteresis in bits 7:4 of 0x64, reset 0x40.
// - Cycle code selects short cycle of 8 to 1024 ticks, long cycle twice that.
// - Short cycle above point minus hysteresis cuts fan-on by twice the rise, none if tiny.
// - Each long cycle above operating point cuts fan-on by one degree more.
// - Fan-on rises only when temp between fan-on and low limit, fan-on under high and point.
module dfl_top #(
  parameter AW = 10
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [AW-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // Monitoring timebase and measured temperatures
  input wire mon_tick,
  input wire [9:0] remote1_temp,
  input wire [9:0] remote2_temp,
  // Fan duty
  output wire [7:0] remote1_duty,
  output wire [7:0] remote2_duty,
  // Interrupt
  output wire irq
);

  // Registers
  reg [7:0] op_q [0:1];
  reg [7:0] tmin_q [0:1];
  reg [7:0] low_q [0:1];
  reg [7:0] high_q [0:1];
  reg [7:0] crit_q [0:1];
  reg [7:0] duty_q [0:1];
  reg [9:0] prev_q [0:1];
  reg [7:0] hyst_q;
  reg [7:0] cycle_q;
  reg [7:0] range_q;
  reg [7:0] ctrl_q;
  reg [7:0] mask_q;
  reg [7:0] rdata_d;
  reg mapped_d;
  integer i;
  integer j;

  // Bus decode
  wire [7:0] idx_w;
  wire setup_w;
  wire wr_w;
  wire rd_w;
  wire [`DFL_STAT_W-1:0] status_w;
  wire [`DFL_STAT_W-1:0] stat_set_w;
  reg [`DFL_STAT_W-1:0] stat_clr_q;

  // Per-channel loop signals
  wire [9:0] temp_w [0:1];
  wire [2:0] cyc_w [0:1];
  wire [2:0] rng_w [0:1];
  wire short_w [0:1];
  wire long_w [0:1];
  wire [7:0] tmin_hw [0:1];
  wire [7:0] duty_d [0:1];
  wire low_evt [0:1];
  wire high_evt [0:1];

  // Register index from the byte address
  assign idx_w = paddr[AW-1:2];
  assign setup_w = psel && !penable;
  assign wr_w = psel && penable && pwrite;
  assign rd_w = psel && penable && !pwrite;
  // No wait states
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped_d;

  // Channel views
  assign temp_w[0] = remote1_temp;
  assign temp_w[1] = remote2_temp;
  assign cyc_w[0] = cycle_q[`DFL_CYC_R1_MSB:`DFL_CYC_R1_LSB];
  assign cyc_w[1] = cycle_q[`DFL_CYC_R2_MSB:`DFL_CYC_R2_LSB];
  assign rng_w[0] = range_q[`DFL_RANGE_R1_MSB:`DFL_RANGE_R1_LSB];
  assign rng_w[1] = range_q[`DFL_RANGE_R2_MSB:`DFL_RANGE_R2_LSB];

  // Duty outputs straight from flip-flops
  assign remote1_duty = duty_q[0];
  assign remote2_duty = duty_q[1];

  // Read mux and address map
  always @*
  begin
    rdata_d = 8'h00;
    mapped_d = 1'b1;
    case (idx_w)
      `DFL_IDX_CYCLE: rdata_d = cycle_q;
      `DFL_IDX_OP1: rdata_d = op_q[0];
      `DFL_IDX_OP2: rdata_d = op_q[1];
      `DFL_IDX_HYST: rdata_d = hyst_q;
      `DFL_IDX_TMIN1: rdata_d = tmin_q[0];
      `DFL_IDX_TMIN2: rdata_d = tmin_q[1];
      `DFL_IDX_LOW1: rdata_d = low_q[0];
      `DFL_IDX_LOW2: rdata_d = low_q[1];
      `DFL_IDX_HIGH1: rdata_d = high_q[0];
      `DFL_IDX_HIGH2: rdata_d = high_q[1];
      `DFL_IDX_CRIT1: rdata_d = crit_q[0];
      `DFL_IDX_CRIT2: rdata_d = crit_q[1];
      `DFL_IDX_RANGE: rdata_d = range_q;
      `DFL_IDX_CTRL: rdata_d = ctrl_q;
      `DFL_IDX_STATUS: rdata_d = {{(8-`DFL_STAT_W){1'b0}}, status_w};
      `DFL_IDX_MASK: rdata_d = mask_q;
      default: mapped_d = 1'b0;
    endcase
  end

  // Read data captured in setup, status bits read are cleared at the access edge
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
      stat_clr_q <= {`DFL_STAT_W{1'b0}};
    end
    else
    begin
      if (setup_w && !pwrite)
        prdata <= {24'h00_0000, rdata_d};
      if (setup_w && !pwrite && idx_w == `DFL_IDX_STATUS)
        stat_clr_q <= status_w;
      // Any other setup drops a pending clear so it is never applied twice
      else if (setup_w || !psel)
        stat_clr_q <= {`DFL_STAT_W{1'b0}};
    end
  end

  // Configuration registers and fan-on temperature
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (i = 0; i < 2; i = i + 1)
      begin
        op_q[i] <= `DFL_RST_OP;
        tmin_q[i] <= `DFL_RST_TMIN;
        low_q[i] <= `DFL_RST_LOW;
        high_q[i] <= `DFL_RST_HIGH;
        crit_q[i] <= `DFL_RST_CRIT;
      end
      hyst_q <= `DFL_RST_HYST;
      cycle_q <= `DFL_RST_CYCLE;
      range_q <= `DFL_RST_RANGE;
      ctrl_q <= `DFL_RST_CTRL;
      mask_q <= `DFL_RST_MASK;
    end
    else
    begin
      // Write decode
      if (wr_w)
      begin
        case (idx_w)
          `DFL_IDX_CYCLE: cycle_q <= pwdata[7:0];
          `DFL_IDX_OP1: op_q[0] <= pwdata[7:0];
          `DFL_IDX_OP2: op_q[1] <= pwdata[7:0];
          `DFL_IDX_HYST: hyst_q <= {pwdata[`DFL_HYST_MSB:`DFL_HYST_LSB], 4'h0};
          `DFL_IDX_LOW1: low_q[0] <= pwdata[7:0];
          `DFL_IDX_LOW2: low_q[1] <= pwdata[7:0];
          `DFL_IDX_HIGH1: high_q[0] <= pwdata[7:0];
          `DFL_IDX_HIGH2: high_q[1] <= pwdata[7:0];
          `DFL_IDX_CRIT1: crit_q[0] <= pwdata[7:0];
          `DFL_IDX_CRIT2: crit_q[1] <= pwdata[7:0];
          `DFL_IDX_RANGE: range_q <= pwdata[7:0];
          `DFL_IDX_CTRL: ctrl_q <= {6'h00, pwdata[1:0]};
          `DFL_IDX_MASK: mask_q <= {{(8-`DFL_STAT_W){1'b0}}, pwdata[`DFL_STAT_W-1:0]};
          default: ;
        endcase
      end
      // Bus write to fan-on wins over the loop update
      for (i = 0; i < 2; i = i + 1)
      begin
        if (wr_w && idx_w == (`DFL_IDX_TMIN1 + i[7:0]))
          tmin_q[i] <= pwdata[7:0];
        else if (ctrl_q[i] && (short_w[i] || long_w[i]))
          tmin_q[i] <= tmin_hw[i];
      end
    end
  end

  // Loop and duty per channel
  genvar c;
  generate
    for (c = 0; c < 2; c = c + 1)
    begin : g_ch
      wire [7:0] ti;
      wire [10:0] thr;
      wire above_thr;
      wire [10:0] rise;
      wire rising;
      wire [9:0] cut;
      wire inc;
      wire [7:0] diff;
      wire [15:0] scaled;

      // Short and long cycle pulses
      dfl_cyc #(
        .CNT_W(11)
      ) u_cyc (
        .pclk(pclk),
        .presetn(presetn),
        .mon_tick(mon_tick),
        .cyc_sel(cyc_w[c]),
        .short_q(short_w[c]),
        .long_q(long_w[c])
      );

      // Whole degree code of the reading
      assign ti = temp_w[c][9:2];
      // Threshold is operating point minus hysteresis, in quarter degrees
      assign thr = {1'b0, op_q[c], 2'b00} - {5'b0_0000, hyst_q[`DFL_HYST_MSB:`DFL_HYST_LSB], 2'b00};
      assign above_thr = thr[10] || ({1'b0, temp_w[c]} > thr);
      // Rise since the previous short-cycle sample
      assign rise = {1'b0, temp_w[c]} - {1'b0, prev_q[c]};
      assign rising = !rise[10] && (rise[9:0] > `DFL_RISE_QUIET);
      // Decrease on short and long cycles, saturating at zero
      assign cut = ((short_w[c] && above_thr && rising) ? {1'b0, rise[9:1]} : 10'h000)
        + ((long_w[c] && ti > op_q[c]) ? 10'h001 : 10'h000);
      // Raise only on a long cycle with no cut
      assign inc = long_w[c] && ti > tmin_q[c] && ti < low_q[c]
        && tmin_q[c] < high_q[c] && tmin_q[c] < op_q[c];
      assign tmin_hw[c] = (cut != 10'h000) ?
        ((cut >= {2'b00, tmin_q[c]}) ? 8'h00 : (tmin_q[c] - cut[7:0])) :
        (inc ? (tmin_q[c] + 8'h01) : tmin_q[c]);

      // Duty curve: off below fan-on, slope from range, full above critical
      assign diff = ti - tmin_q[c];
      assign scaled = {8'h00, diff} << rng_w[c];
      assign duty_d[c] = (ti > crit_q[c]) ? `DFL_DUTY_FULL :
        (ti < tmin_q[c]) ? `DFL_DUTY_OFF :
        ((scaled[15:8] != 8'h00) ? `DFL_DUTY_FULL : scaled[7:0]);

      // Limit events on each monitoring tick
      assign low_evt[c] = mon_tick && (ti < low_q[c]);
      assign high_evt[c] = mon_tick && (ti > high_q[c]);
    end
  endgenerate

  // Short-cycle sample and registered duty, one process for both channels
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (j = 0; j < 2; j = j + 1)
      begin
        prev_q[j] <= 10'h000;
        duty_q[j] <= `DFL_DUTY_OFF;
      end
    end
    else
    begin
      for (j = 0; j < 2; j = j + 1)
      begin
        if (short_w[j])
          prev_q[j] <= temp_w[j];
        duty_q[j] <= duty_d[j];
      end
    end
  end

  // Status: bit 0 low, 1 high, 2 low, 3 high
  assign stat_set_w = {high_evt[1], low_evt[1], high_evt[0], low_evt[0]};

  // Sticky status, set wins over the read clear
  dfl_sticky #(
    .W(`DFL_STAT_W)
  ) u_status (
    .pclk(pclk),
    .presetn(presetn),
    .set(stat_set_w),
    .clr(stat_clr_q & {`DFL_STAT_W{rd_w}}),
    .q(status_w)
  );

  // Level interrupt from unmasked sticky bits
  assign irq = |(status_w & mask_q[`DFL_STAT_W-1:0]);

endmodule

// [tb/dfl_properties.sv]
// Purpose: Port-level checks of the fan threshold loop
// Assumes: Zero wait state APB slave, index in paddr[9:2]
// Notes: Bound to dfl_top from the bench
`timescale 1ns/1ps
module dfl_chk #(
  parameter AW = 10
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Loop
  input wire logic mon_tick,
  input wire logic irq
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire [7:0] idx = paddr[9:2];
  wire acc = psel && penable;
  wire wr_acc = acc && pwrite;
  wire rd_setup = psel && !penable && !pwrite;
  ready_always_a: assert property (pready) else $error("pready low");
  err_phase_a: assert property (pslverr |-> acc) else $error("pslverr outside access");
  err_unmapped_a: assert property (acc && idx == 8'h00 |-> pslverr)
    else $error("unmapped index without pslverr");
  err_mapped_a: assert property (acc && (idx == 8'h5A || idx == 8'h5B || idx == 8'h64)
    |-> !pslverr) else $error("mapped index with pslverr");
  rdata_upper_a: assert property (prdata[31:8] == 24'h00_0000)
    else $error("upper read bits set");
  rdata_hold_a: assert property (!rd_setup |=> $stable(prdata))
    else $error("prdata moved outside read");
  hyst_nibble_a: assert property (rd_setup && idx == 8'h64 |=> prdata[3:0] == 4'h0)
    else $error("hysteresis low nibble set");
  unmapped_zero_a: assert property (rd_setup && idx == 8'h00 |=> prdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  irq_rise_a: assert property ($rose(irq) |-> $past(mon_tick) || $past(wr_acc))
    else $error("irq rose without event");
  irq_fall_a: assert property ($fell(irq) |-> $past(acc))
    else $error("irq fell without access");
  cover property ($rose(irq));
  cover property (acc && pslverr);
  cover property (rd_setup && idx == 8'h7A);
endmodule

// [tb/dfl_env.sv]
// Purpose: Remote sensor model: one conversion per monitoring cycle
// Assumes: Bench requests temperatures, model publishes them on the tick
// Notes: Tick period is a parameter
`timescale 1ns/1ps
module dfl_env #(
  parameter TICK = 8
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Requested temperatures
  input wire [9:0] t1_req,
  input wire [9:0] t2_req,
  // Sensor side
  output reg mon_tick,
  output reg [9:0] remote1_temp,
  output reg [9:0] remote2_temp
);
  integer cnt;
  // A new reading lands together with the tick
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt <= 0;
      mon_tick <= 1'b0;
      remote1_temp <= 10'h220;
      remote2_temp <= 10'h220;
    end
    else
    begin
      cnt <= (cnt == TICK - 1) ? 0 : cnt + 1;
      mon_tick <= (cnt == TICK - 1);
      if (cnt == TICK - 1)
      begin
        remote1_temp <= t1_req;
        remote2_temp <= t2_req;
      end
    end
  end
endmodule

// [tb/tb_dfl_top.sv]
// Purpose: Self-checking bench of the fan threshold loop
// Assumes: Degree codes in temp[9:2], tick every 8 clocks
// Notes: Dynamic windows span 16, 8 and 24 monitoring ticks
`timescale 1ns/1ps
module tb_dfl_top;
  reg pclk = 1'b0;
  reg presetn = 1'b0;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [9:0] paddr = 10'h000;
  reg [31:0] pwdata = 32'h0000_0000;
  reg [9:0] t1 = 10'h220;
  reg [9:0] t2 = 10'h220;
  reg [31:0] rd;
  wire [31:0] prdata;
  wire pready, pslverr, mon_tick, irq;
  wire [9:0] r1t, r2t;
  wire [7:0] d1, d2;
  integer mismatches = 0;
  integer total_checks = 0;
  integer cyc = 0;
  always #12.5 pclk = ~pclk;
  dfl_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mon_tick(mon_tick), .remote1_temp(r1t), .remote2_temp(r2t),
    .remote1_duty(d1), .remote2_duty(d2), .irq(irq));
  dfl_env u_env (.pclk(pclk), .presetn(presetn), .t1_req(t1), .t2_req(t2),
    .mon_tick(mon_tick), .remote1_temp(r1t), .remote2_temp(r2t));
  task summarize;
    begin
      $display("checks=%0d mismatches=%0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  task check(input [31:0] seen, input [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (seen !== exp)
      begin
        mismatches = mismatches + 1;
        $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task apb(input wr, input [7:0] idx, input [31:0] wd);
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do
        @(posedge pclk);
      while (pready !== 1'b1);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task ticks(input integer n);
    begin
      // A tick seen at the next edge may still carry the old reading
      @(posedge pclk);
      repeat (n)
      begin
        @(posedge pclk);
        while (mon_tick !== 1'b1)
          @(posedge pclk);
      end
      repeat (3) @(posedge pclk);
    end
  endtask
  task t_regs;
    begin
      apb(1'b0, 8'h5A, 32'h0000_0000);
      check(rd, 32'h0000_00A4);
      apb(1'b0, 8'h5B, 32'h0000_0000);
      check(rd, 32'h0000_00A4);
      apb(1'b0, 8'h64, 32'h0000_0000);
      check(rd, 32'h0000_0040);
      apb(1'b1, 8'h5B, 32'hFFFF_FF55);
      apb(1'b0, 8'h5B, 32'h0000_0000);
      check(rd, 32'h0000_0055);
      apb(1'b1, 8'h64, 32'h0000_00FF);
      apb(1'b0, 8'h64, 32'h0000_0000);
      check(rd, 32'h0000_00F0);
      apb(1'b1, 8'h00, 32'h0000_00FF);
      apb(1'b0, 8'h00, 32'h0000_0000);
      check(rd, 32'h0000_0000);
      apb(1'b1, 8'h5B, 32'h0000_00A4);
      apb(1'b1, 8'h64, 32'h0000_0040);
    end
  endtask
  task t_events;
    integer k;
    begin
      apb(1'b1, 8'h7B, 32'h0000_000F);
      for (k = 0; k < 5; k = k + 1)
      begin
        if (k == 4)
          apb(1'b1, 8'h7B, 32'h0000_0000);
        if (k < 2 || k == 4)
          t1 <= k[0] ? 10'h270 : 10'h200;
        else
          t2 <= k[0] ? 10'h270 : 10'h200;
        ticks(1);
        check({31'h0, irq}, (k < 4) ? 32'h0000_0001 : 32'h0000_0000);
        t1 <= 10'h220;
        t2 <= 10'h220;
        ticks(1);
        apb(1'b0, 8'h7A, 32'h0000_0000);
        check(rd, 32'h0000_0001 << (k % 4));
        @(posedge pclk);
        check({31'h0, irq}, 32'h0000_0000);
      end
    end
  endtask
  task duty(input [7:0] code, input [7:0] rng, input [7:0] exp);
    begin
      apb(1'b1, 8'h78, {24'h00_0000, rng});
      t1 <= {code, 2'b00};
      t2 <= {code, 2'b00};
      ticks(1);
      check({24'h00_0000, d1}, {24'h00_0000, exp});
      check({24'h00_0000, d2}, {24'h00_0000, exp});
    end
  endtask
  // Basic loop values go in before the dynamic enable
  task dyn(input [7:0] tmin, input [9:0] ta, input [9:0] tz, input [2:0] cy,
    input [7:0] exp);
    begin
      apb(1'b1, 8'h70, {24'h00_0000, tmin});
      apb(1'b1, 8'h5A, 32'h0000_0090);
      apb(1'b1, 8'h0C, {29'h0, cy});
      t1 <= ta;
      ticks(16);
      apb(1'b1, 8'h79, 32'h0000_0001);
      ticks(8);
      t1 <= tz;
      ticks(24);
      apb(1'b1, 8'h79, 32'h0000_0000);
      apb(1'b0, 8'h70, 32'h0000_0000);
      check(rd, {24'h00_0000, exp});
    end
  endtask
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_events;
    duty(8'h88, 8'h22, 8'h00);
    duty(8'h8E, 8'h22, 8'h08);
    duty(8'h8E, 8'h33, 8'h10);
    duty(8'hA0, 8'h77, 8'hFF);
    duty(8'hA5, 8'h22, 8'hFF);
    dyn(8'h8C, 10'h234, 10'h235, 3'h0, 8'h8C);
    dyn(8'h8C, 10'h234, 10'h238, 3'h0, 8'h8A);
    dyn(8'h8C, 10'h254, 10'h254, 3'h0, 8'h8A);
    dyn(8'h70, 10'h1E0, 10'h1E0, 3'h0, 8'h72);
    dyn(8'h70, 10'h1E0, 10'h1E0, 3'h1, 8'h71);
    summarize;
  end
  always @(posedge pclk)
  begin
    cyc = cyc + 1;
    if (cyc == 20000)
    begin
      mismatches = mismatches + 1;
      summarize;
    end
  end
endmodule
bind dfl_top dfl_chk #(.AW(AW)) u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .mon_tick(mon_tick), .irq(irq));
